// file: rtl/csdec_consts.svh
// select code values, timing counts and reset values of the select decoder
// assumes a 10 MHz ref_clk and a five bit select code
//
// How it works
// (R1) decode only while select_qualifier_n is 0 and dma_ack_inhibit is 0, except the 16H resume code
// (R2) controller drives five bit code, code_bit4 most significant, one function per code
// (R3) code 00H asserts bios_rom_oe
// (R4) code 01H asserts kbd_ctrl_sel
// (R5) code 02H asserts coproc_sel
// (R6) code 03H strobes pcu0_wr_strobe, code 17H strobes pcu1_wr_strobe
// (R7) code 04H asserts kbd_proc_ack
// (R8) code 05H asserts clock chip address latch enable
// (R9) code 06H gives clock chip write strobe while qualifier and io write active
// (R10) code 07H gives clock chip read strobe while qualifier and io read active
// (R11) code 08H asserts fdc_output_reg_sel
// (R12) code 09H asserts fdc_core_sel
// (R13) codes 0AH and 0BH select rate register; 0BH adds ide_low_buf_en, ide_sel1
// (R14) 0CH: low buffer, ide_sel0, high buffer if a0 low; 0DH: low buffer, ide_sel1
// (R15) 0EH serial_a_sel, 0FH parallel0_sel, 10H serial_b_sel
// (R16) 11H prog_sel, 14H expanded_mem_access
// (R17) 15H with qualifier and io write on clock fall enters suspend, holds port selects
// (R18) 16H on clock fall leaves suspend, enables 48 MHz clock, drops port selects
// (R19) with address latch in use, decode from the latched code copy
// (R20) power-down options and suspend float floppy drive outputs, raise powerdown_flag
// (R21) suspend clock output runs 32.768 KHz in suspend, 14.318 MHz otherwise
// (R22) suspend emits a 1 us refresh pulse every 15.2 us (152 ref_clk cycles)
// (R23) in power-down floppy dma request and interrupt float unless dma_enable_bit is 1
// (R24) unassigned codes leave every decoded output deasserted, except the port selects held in suspend
`ifndef CSDEC_CONSTS_SVH
`define CSDEC_CONSTS_SVH

// ------------------------------------------------------------
// select codes
// ------------------------------------------------------------
`define CODE_BIOS_ROM 5'h00
`define CODE_KBD_CTRL 5'h01
`define CODE_COPROC 5'h02
`define CODE_PCU0 5'h03
`define CODE_KBD_ACK 5'h04
`define CODE_RTC_ALE 5'h05
`define CODE_RTC_WR 5'h06
`define CODE_RTC_RD 5'h07
`define CODE_FDC_OUT 5'h08
`define CODE_FDC_CORE 5'h09
`define CODE_FDC_RATE 5'h0A
`define CODE_RATE_IDE1 5'h0B
`define CODE_IDE0 5'h0C
`define CODE_IDE1 5'h0D
`define CODE_SERIAL_A 5'h0E
`define CODE_PARALLEL0 5'h0F
`define CODE_SERIAL_B 5'h10
`define CODE_PROG 5'h11
`define CODE_EXP_MEM 5'h14
`define CODE_SUSPEND 5'h15
`define CODE_RESUME 5'h16
`define CODE_PCU1 5'h17

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define CODE_W 5
`define CODE_COUNT 32
`define FDD_W 13
`define CODE_RESET 5'h1F

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define REF_CLK_PERIOD_NS 100
`define REFRESH_PERIOD_NS 15260
`define REFRESH_PULSE_NS 1000
`define REFRESH_PERIOD_CYC (`REFRESH_PERIOD_NS / `REF_CLK_PERIOD_NS)
`define REFRESH_PULSE_CYC (`REFRESH_PULSE_NS / `REF_CLK_PERIOD_NS)
`define REFRESH_CNT_W 8

`endif

// file: rtl/csdec_pkg.sv
// types of the select decoder
// assumes csdec_consts.svh for the figures
package csdec_pkg;

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  typedef enum logic {
    PWR_RUN,
    PWR_SUSPEND
  } pwr_state_t;

endpackage : csdec_pkg

// file: rtl/code_latch.sv
// holds a copy of the select code captured while the address latch strobe is high
// assumes inputs synchronous to ref_clk
`timescale 1ns/100ps
`include "csdec_consts.svh"

module code_latch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // code in
  input wire logic addr_latch_strobe,
  input wire logic [`CODE_W-1:0] code_in,
  // code out
  output logic [`CODE_W-1:0] code_held
);

  logic [`CODE_W-1:0] code_reg;
  logic [`CODE_W-1:0] code_next;

  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  assign code_next = addr_latch_strobe ? code_in : code_reg; // R19

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_reg <= `CODE_RESET;
    end else if (clk_en) begin
      code_reg <= code_next;
    end
  end

  assign code_held = code_reg;

endmodule : code_latch

// file: rtl/chip_select_decoder.sv
// select code decoder with suspend control and power-down pin gating
// assumes all inputs synchronous to ref_clk; osc14_ref and rtc32_ref are
// square-wave references already brought into the ref_clk domain
`timescale 1ns/100ps
`include "csdec_consts.svh"

module chip_select_decoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // select code and qualifiers
  input wire logic select_qualifier_n,
  input wire logic dma_ack_inhibit,
  input wire logic code_bit4,
  input wire logic code_bit3,
  input wire logic code_bit2,
  input wire logic code_bit1,
  input wire logic code_bit0,
  input wire logic addr_latch_used,
  input wire logic addr_latch_strobe,
  input wire logic io_write_n,
  input wire logic io_read_n,
  input wire logic a0,
  // decoded selects
  output logic bios_rom_oe,
  output logic kbd_ctrl_sel,
  output logic coproc_sel,
  output logic pcu0_wr_strobe,
  output logic pcu1_wr_strobe,
  output logic kbd_proc_ack,
  output logic rtc_addr_latch,
  output logic rtc_wr_strobe,
  output logic rtc_rd_strobe,
  output logic fdc_output_reg_sel,
  output logic fdc_core_sel,
  output logic fdc_rate_reg_sel,
  output logic ide_low_buf_en,
  output logic ide_high_buf_en,
  output logic ide_sel0,
  output logic ide_sel1,
  output logic serial_a_sel,
  output logic serial_b_sel,
  output logic parallel0_sel,
  output logic prog_sel,
  output logic expanded_mem_access,
  output logic decode_oe,
  // suspend
  input wire logic osc14_ref,
  input wire logic rtc32_ref,
  output logic suspend_clock_out,
  output logic suspend_refresh,
  output logic clk48_en,
  output logic in_suspend,
  // power-down and floppy pins
  input wire logic pd_opt1,
  input wire logic pd_opt2,
  input wire logic dma_enable_bit,
  input wire logic [`FDD_W-1:0] fdd_drive_in,
  input wire logic fdc_dma_req_in,
  input wire logic fdc_irq_in,
  output logic [`FDD_W-1:0] fdd_drive_out,
  output logic fdd_drive_oe,
  output logic fdc_dma_req_out,
  output logic fdc_irq_out,
  output logic fdc_dma_irq_oe,
  output logic powerdown_flag
);

  // ------------------------------------------------------------
  // code selection
  // ------------------------------------------------------------
  logic [`CODE_W-1:0] live_code;
  logic [`CODE_W-1:0] held_code;
  logic [`CODE_W-1:0] code;
  logic qualified;
  logic [`CODE_COUNT-1:0] hit;

  assign live_code = {code_bit4, code_bit3, code_bit2, code_bit1, code_bit0}; // R2

  code_latch u_code_latch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .addr_latch_strobe(addr_latch_strobe),
    .code_in(live_code),
    .code_held(held_code)
  );

  assign code = addr_latch_used ? held_code : live_code; // R19
  assign qualified = !select_qualifier_n && !dma_ack_inhibit; // R1

  // one decode line per code; unassigned lines are never read
  genvar gi;
  generate
    for (gi = 0; gi < `CODE_COUNT; gi = gi + 1) begin : g_hit
      assign hit[gi] = qualified && (code == `CODE_W'(gi)); // R1 R24
    end
  endgenerate

  // ------------------------------------------------------------
  // output decode
  // ------------------------------------------------------------
  logic suspend_active;
  logic rom_next;
  logic kbd_next;
  logic coproc_next;
  logic pcu0_next;
  logic pcu1_next;
  logic kack_next;
  logic ale_next;
  logic rtcw_next;
  logic rtcr_next;
  logic fout_next;
  logic fcore_next;
  logic frate_next;
  logic idel_next;
  logic ideh_next;
  logic ide0_next;
  logic ide1_next;
  logic sera_next;
  logic serb_next;
  logic par0_next;
  logic prog_next;
  logic ems_next;

  assign rom_next = hit[`CODE_BIOS_ROM]; // R3
  assign kbd_next = hit[`CODE_KBD_CTRL]; // R4
  assign coproc_next = hit[`CODE_COPROC]; // R5
  assign pcu0_next = hit[`CODE_PCU0]; // R6
  assign pcu1_next = hit[`CODE_PCU1]; // R6
  assign kack_next = hit[`CODE_KBD_ACK]; // R7
  assign ale_next = hit[`CODE_RTC_ALE]; // R8
  assign rtcw_next = hit[`CODE_RTC_WR] && !io_write_n; // R9
  assign rtcr_next = hit[`CODE_RTC_RD] && !io_read_n; // R10
  assign fout_next = hit[`CODE_FDC_OUT]; // R11
  assign fcore_next = hit[`CODE_FDC_CORE]; // R12
  assign frate_next = hit[`CODE_FDC_RATE] || hit[`CODE_RATE_IDE1]; // R13
  assign idel_next = hit[`CODE_RATE_IDE1] || hit[`CODE_IDE0] || hit[`CODE_IDE1]; // R13 R14
  assign ideh_next = hit[`CODE_IDE0] && !a0; // R14
  assign ide0_next = hit[`CODE_IDE0]; // R14
  assign ide1_next = hit[`CODE_RATE_IDE1] || hit[`CODE_IDE1]; // R13 R14
  assign sera_next = hit[`CODE_SERIAL_A] || suspend_active; // R15 R17
  assign par0_next = hit[`CODE_PARALLEL0] || suspend_active; // R15 R17
  assign serb_next = hit[`CODE_SERIAL_B] || suspend_active; // R15 R17
  assign prog_next = hit[`CODE_PROG]; // R16
  assign ems_next = hit[`CODE_EXP_MEM]; // R16

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bios_rom_oe <= 1'b0;
      kbd_ctrl_sel <= 1'b0;
      coproc_sel <= 1'b0;
      pcu0_wr_strobe <= 1'b0;
      pcu1_wr_strobe <= 1'b0;
      kbd_proc_ack <= 1'b0;
      rtc_addr_latch <= 1'b0;
      rtc_wr_strobe <= 1'b0;
      rtc_rd_strobe <= 1'b0;
      fdc_output_reg_sel <= 1'b0;
      fdc_core_sel <= 1'b0;
      fdc_rate_reg_sel <= 1'b0;
    end else if (clk_en) begin
      bios_rom_oe <= rom_next;
      kbd_ctrl_sel <= kbd_next;
      coproc_sel <= coproc_next;
      pcu0_wr_strobe <= pcu0_next;
      pcu1_wr_strobe <= pcu1_next;
      kbd_proc_ack <= kack_next;
      rtc_addr_latch <= ale_next;
      rtc_wr_strobe <= rtcw_next;
      rtc_rd_strobe <= rtcr_next;
      fdc_output_reg_sel <= fout_next;
      fdc_core_sel <= fcore_next;
      fdc_rate_reg_sel <= frate_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ide_low_buf_en <= 1'b0;
      ide_high_buf_en <= 1'b0;
      ide_sel0 <= 1'b0;
      ide_sel1 <= 1'b0;
      serial_a_sel <= 1'b0;
      serial_b_sel <= 1'b0;
      parallel0_sel <= 1'b0;
      prog_sel <= 1'b0;
      expanded_mem_access <= 1'b0;
    end else if (clk_en) begin
      ide_low_buf_en <= idel_next;
      ide_high_buf_en <= ideh_next;
      ide_sel0 <= ide0_next;
      ide_sel1 <= ide1_next;
      serial_a_sel <= sera_next;
      serial_b_sel <= serb_next;
      parallel0_sel <= par0_next;
      prog_sel <= prog_next;
      expanded_mem_access <= ems_next;
    end
  end

  // ------------------------------------------------------------
  // suspend state
  // ------------------------------------------------------------
  csdec_pkg::pwr_state_t state_reg;
  csdec_pkg::pwr_state_t state_next;
  logic clk_prev_reg;
  logic clk_fall;
  logic enter_req;
  logic exit_req;
  logic clk_next;

  assign clk_fall = clk_prev_reg && !suspend_clock_out;
  assign enter_req = (code == `CODE_SUSPEND) && !select_qualifier_n
                     && !dma_ack_inhibit && !io_write_n && clk_fall; // R17
  assign exit_req = (code == `CODE_RESUME) && clk_fall; // R18

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csdec_pkg::PWR_RUN: begin
        if (enter_req) begin
          state_next = csdec_pkg::PWR_SUSPEND; // R17
        end
      end
      csdec_pkg::PWR_SUSPEND: begin
        if (exit_req) begin
          state_next = csdec_pkg::PWR_RUN; // R18
        end
      end
      default: begin
        state_next = csdec_pkg::PWR_RUN;
      end
    endcase
  end

  assign suspend_active = (state_reg == csdec_pkg::PWR_SUSPEND);
  assign clk_next = suspend_active ? rtc32_ref : osc14_ref; // R21

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= csdec_pkg::PWR_RUN;
      clk_prev_reg <= 1'b0;
      suspend_clock_out <= 1'b0;
      clk48_en <= 1'b1;
      in_suspend <= 1'b0;
      decode_oe <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      clk_prev_reg <= suspend_clock_out;
      suspend_clock_out <= clk_next; // R21
      clk48_en <= !suspend_active; // R17 R18
      in_suspend <= suspend_active;
      decode_oe <= !suspend_active;
    end
  end

  // ------------------------------------------------------------
  // suspend refresh
  // ------------------------------------------------------------
  logic [`REFRESH_CNT_W-1:0] ref_cnt_reg;
  logic [`REFRESH_CNT_W-1:0] ref_cnt_next;
  logic ref_wrap;
  logic refresh_next;

  assign ref_wrap = (ref_cnt_reg == `REFRESH_CNT_W'(`REFRESH_PERIOD_CYC - 1));
  assign ref_cnt_next = (!suspend_active || ref_wrap) ? '0 : ref_cnt_reg + 1'b1; // R22
  assign refresh_next = suspend_active
                        && (ref_cnt_reg < `REFRESH_CNT_W'(`REFRESH_PULSE_CYC)); // R22

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_reg <= '0;
      suspend_refresh <= 1'b0;
    end else if (clk_en) begin
      ref_cnt_reg <= ref_cnt_next;
      suspend_refresh <= refresh_next;
    end
  end

  // ------------------------------------------------------------
  // power-down pin gating
  // ------------------------------------------------------------
  logic low_power;
  logic dma_irq_oe_next;

  assign low_power = pd_opt1 || pd_opt2 || suspend_active; // R20
  assign dma_irq_oe_next = !(suspend_active
                             || ((pd_opt1 || pd_opt2) && !dma_enable_bit)); // R23

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fdd_drive_out <= '0;
      fdd_drive_oe <= 1'b0;
      fdc_dma_req_out <= 1'b0;
      fdc_irq_out <= 1'b0;
      fdc_dma_irq_oe <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (clk_en) begin
      fdd_drive_out <= fdd_drive_in;
      fdd_drive_oe <= !low_power; // R20
      fdc_dma_req_out <= fdc_dma_req_in;
      fdc_irq_out <= fdc_irq_in;
      fdc_dma_irq_oe <= dma_irq_oe_next; // R23
      powerdown_flag <= low_power; // R20
    end
  end

endmodule : chip_select_decoder

// file: verif/ctrl_model.sv
// controller side model: presents the select code on the five code lines
// assumes the bench calls put just after a falling ref_clk edge
`timescale 1ns/100ps

module ctrl_model (
  // select code lines
  output logic code_bit4,
  output logic code_bit3,
  output logic code_bit2,
  output logic code_bit1,
  output logic code_bit0
);
  initial {code_bit4, code_bit3, code_bit2, code_bit1, code_bit0} = 5'h1F;
  // one function per code, code_bit4 most significant
  task put(input logic [4:0] c);
    {code_bit4, code_bit3, code_bit2, code_bit1, code_bit0} = c;
  endtask : put
endmodule : ctrl_model

// file: verif/csdec_asserts.sv
// timing checks on the select decoder ports
// assumes bind into chip_select_decoder, one ref_clk domain
`timescale 1ns/100ps

module csdec_asserts (
  // clock, reset and inputs
  input wire logic ref_clk, rst_b, select_qualifier_n, dma_ack_inhibit,
  input wire logic io_write_n, io_read_n, a0, osc14_ref, rtc32_ref,
  input wire logic pd_opt1, pd_opt2, dma_enable_bit,
  // outputs
  input wire logic bios_rom_oe, kbd_ctrl_sel, coproc_sel, pcu0_wr_strobe,
  input wire logic pcu1_wr_strobe, kbd_proc_ack, rtc_addr_latch, rtc_wr_strobe,
  input wire logic rtc_rd_strobe, fdc_output_reg_sel, fdc_core_sel, fdc_rate_reg_sel,
  input wire logic ide_low_buf_en, ide_high_buf_en, ide_sel0, ide_sel1,
  input wire logic serial_a_sel, serial_b_sel, parallel0_sel, prog_sel,
  input wire logic expanded_mem_access, suspend_clock_out, suspend_refresh,
  input wire logic clk48_en, in_suspend, fdd_drive_oe, fdc_dma_irq_oe, powerdown_flag
);
  wire logic qual = !select_qualifier_n && !dma_ack_inhibit;
  wire logic [20:0] sel = {bios_rom_oe, kbd_ctrl_sel, coproc_sel, pcu0_wr_strobe,
    pcu1_wr_strobe, kbd_proc_ack, rtc_addr_latch, rtc_wr_strobe, rtc_rd_strobe,
    fdc_output_reg_sel, fdc_core_sel, fdc_rate_reg_sel, ide_low_buf_en, ide_high_buf_en,
    ide_sel0, ide_sel1, serial_a_sel, serial_b_sel, parallel0_sel, prog_sel,
    expanded_mem_access};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  no_qual_sel_a: assert property (!qual |=> (sel & 21'h1FFFE3) == 21'h000000
    && (in_suspend || sel == 21'h000000)) else $error("select without qualifier");
  rtc_wr_gate_a: assert property (rtc_wr_strobe |-> $past(qual && !io_write_n))
    else $error("rtc write ungated");
  rtc_rd_gate_a: assert property (rtc_rd_strobe |-> $past(qual && !io_read_n))
    else $error("rtc read ungated");
  ide_high_pair_a: assert property (ide_high_buf_en |-> ide_sel0 && ide_low_buf_en
    && $past(!a0)) else $error("ide high buffer bad");
  ide_sel1_pair_a: assert property (ide_sel1 |-> ide_low_buf_en && !ide_sel0)
    else $error("ide select 1 bad");
  pwr_flag_a: assert property ($past(rst_b) |-> fdd_drive_oe == !powerdown_flag
    && powerdown_flag == ($past(pd_opt1 || pd_opt2) || in_suspend))
    else $error("powerdown flag bad");
  dma_float_a: assert property ($past(rst_b) |-> fdc_dma_irq_oe ==
    !(in_suspend || $past((pd_opt1 || pd_opt2) && !dma_enable_bit))) else $error("dma oe bad");
  port_hold_a: assert property (in_suspend |-> serial_a_sel && serial_b_sel
    && parallel0_sel && !clk48_en) else $error("suspend holds bad");
  clk48_run_a: assert property (!in_suspend |-> clk48_en) else $error("48 clock off");
  osc_select_a: assert property ($past(rst_b) |-> suspend_clock_out ==
    (in_suspend ? $past(rtc32_ref) : $past(osc14_ref))) else $error("suspend clock bad");
  refresh_width_a: assert property (@(posedge ref_clk) disable iff (!rst_b || !in_suspend)
    $rose(suspend_refresh) |=> suspend_refresh [*8] ##1 suspend_refresh ##1 !suspend_refresh)
    else $error("refresh width bad");
endmodule : csdec_asserts

bind chip_select_decoder csdec_asserts chk (.*);

// file: verif/test_chip_select_decoder.sv
// self-checking bench of the select decoder with random and swept codes
// assumes ctrl_model drives the code lines and csdec_asserts is bound
`timescale 1ns/100ps
`include "csdec_consts.svh"

module test_chip_select_decoder;
  logic ref_clk, rst_b, clk_en, select_qualifier_n, dma_ack_inhibit, addr_latch_used;
  logic addr_latch_strobe, io_write_n, io_read_n, a0, osc14_ref, rtc32_ref, pd, pd_opt1;
  logic pd_opt2, dma_enable_bit, fdc_dma_req_in, fdc_irq_in, fdc_dma_req_out, fdc_irq_out;
  logic bios_rom_oe, kbd_ctrl_sel, coproc_sel, pcu0_wr_strobe, pcu1_wr_strobe, kbd_proc_ack;
  logic rtc_addr_latch, rtc_wr_strobe, rtc_rd_strobe, fdc_output_reg_sel, fdc_core_sel;
  logic fdc_rate_reg_sel, ide_low_buf_en, ide_high_buf_en, ide_sel0, ide_sel1, serial_a_sel;
  logic serial_b_sel, parallel0_sel, prog_sel, expanded_mem_access, decode_oe;
  logic suspend_clock_out, suspend_refresh, clk48_en, in_suspend, fdd_drive_oe;
  logic fdc_dma_irq_oe, powerdown_flag;
  logic [`FDD_W-1:0] fdd_drive_in, fdd_drive_out;
  wire logic code_bit4, code_bit3, code_bit2, code_bit1, code_bit0;
  logic [15:0] s, u, v;
  logic [4:0] lat;
  logic [38:0] ex;
  int errors, checks_done, hi;
  wire logic [38:0] obs = {bios_rom_oe, kbd_ctrl_sel, coproc_sel, pcu0_wr_strobe,
    pcu1_wr_strobe, kbd_proc_ack, rtc_addr_latch, rtc_wr_strobe, rtc_rd_strobe,
    fdc_output_reg_sel, fdc_core_sel, fdc_rate_reg_sel, ide_low_buf_en, ide_high_buf_en,
    ide_sel0, ide_sel1, serial_a_sel, serial_b_sel, parallel0_sel, prog_sel,
    expanded_mem_access, powerdown_flag, fdd_drive_oe, fdc_dma_irq_oe, fdd_drive_out,
    fdc_dma_req_out, fdc_irq_out};

  ctrl_model ctl (.code_bit4, .code_bit3, .code_bit2, .code_bit1, .code_bit0);
  chip_select_decoder DUT (.*);

  always #50 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [20:0] exp_sel(input logic [4:0] c);
    logic [20:0] e;
    case (c)
      5'h00: e = 21'h100000;
      5'h01: e = 21'h080000;
      5'h02: e = 21'h040000;
      5'h03: e = 21'h020000;
      5'h17: e = 21'h010000;
      5'h04: e = 21'h008000;
      5'h05: e = 21'h004000;
      5'h06: e = io_write_n ? 21'h000000 : 21'h002000;
      5'h07: e = io_read_n ? 21'h000000 : 21'h001000;
      5'h08: e = 21'h000800;
      5'h09: e = 21'h000400;
      5'h0A: e = 21'h000200;
      5'h0B: e = 21'h000320;
      5'h0C: e = a0 ? 21'h000140 : 21'h0001C0;
      5'h0D: e = 21'h000120;
      5'h0E: e = 21'h000010;
      5'h0F: e = 21'h000004;
      5'h10: e = 21'h000008;
      5'h11: e = 21'h000002;
      5'h14: e = 21'h000001;
      default: e = 21'h000000;
    endcase
    if (select_qualifier_n || dma_ack_inhibit) e = 21'h000000;
    return e;
  endfunction : exp_sel

  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task cmp(input logic [38:0] g, input logic [38:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp

  task wait_for(input logic lvl);
    for (int k = 0; k < 40 && in_suspend !== lvl; k++) begin
      @(negedge ref_clk);
      osc14_ref = ~osc14_ref;
      rtc32_ref = ~rtc32_ref;
    end
    if (in_suspend !== lvl) begin
      errors++;
      $display("Error at %0t: suspend change timed out", $time);
      final_report();
    end
  endtask : wait_for

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {clk_en, select_qualifier_n, io_write_n, io_read_n, ref_clk, rst_b} = 6'h3C;
    {dma_ack_inhibit, addr_latch_used, addr_latch_strobe, a0, osc14_ref, rtc32_ref} = 6'h00;
    {pd_opt1, pd_opt2, dma_enable_bit, fdc_dma_req_in, fdc_irq_in} = 5'h00;
    fdd_drive_in = 13'h0000;
    {errors, checks_done, s, lat} = {32'h0, 32'h0, 16'h7110, 5'h1F};
    repeat (3) @(negedge ref_clk);
    rst_b = 1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      if (i > 0) cmp(obs, ex);
      s = lfsr(s);
      u = s;
      s = lfsr(s);
      v = s;
      if (i < 64) u = {u[15], i[5], ~i[5], i[5], 1'b0, u[10], 5'h00, i[4:0]};
      ctl.put(u[4:0]);
      {select_qualifier_n, dma_ack_inhibit} = {u[5] & u[6], u[7] & u[8] & u[9]};
      {io_write_n, io_read_n, a0, addr_latch_used, addr_latch_strobe} = u[14:10];
      {pd_opt1, pd_opt2, dma_enable_bit} = {v[0] & v[1], v[2] & v[3], v[4]};
      {fdd_drive_in, fdc_dma_req_in, fdc_irq_in} = {v[15:3], u[15], v[1]};
      pd = pd_opt1 | pd_opt2;
      ex = {exp_sel(addr_latch_used ? lat : u[4:0]), pd, !pd, !(pd & !dma_enable_bit),
        fdd_drive_in, fdc_dma_req_in, fdc_irq_in};
      if (addr_latch_strobe) lat = u[4:0];
    end
    ctl.put(5'h15);
    {select_qualifier_n, dma_ack_inhibit, io_write_n, addr_latch_used, pd_opt1, pd_opt2} = 6'h00;
    wait_for(1'b1);
    cmp(39'({clk48_en, decode_oe, serial_a_sel, serial_b_sel, parallel0_sel, powerdown_flag,
      fdd_drive_oe, fdc_dma_irq_oe}), 39'h3C);
    ctl.put(5'h01);
    {select_qualifier_n, io_write_n, hi} = {2'h3, 32'h0};
    repeat (152) begin
      @(negedge ref_clk);
      rtc32_ref = ~rtc32_ref;
      hi += suspend_refresh;
    end
    cmp(39'(hi), 39'h0A);
    cmp(39'({serial_a_sel, serial_b_sel, parallel0_sel, kbd_ctrl_sel}), 39'hE);
    ctl.put(5'h16);
    wait_for(1'b0);
    cmp(39'({clk48_en, decode_oe, serial_a_sel, serial_b_sel, parallel0_sel, powerdown_flag}),
      39'h30);
    // clock enable low freezes the decode, high lets it through
    @(negedge ref_clk);
    {clk_en, select_qualifier_n} = 2'b00;
    ctl.put(5'h00);
    repeat (2) @(negedge ref_clk);
    cmp(39'({bios_rom_oe, in_suspend, clk48_en}), 39'h1);
    clk_en = 1'b1;
    @(negedge ref_clk);
    cmp(39'({bios_rom_oe, in_suspend, clk48_en}), 39'h5);
    rst_b = 0;
    @(negedge ref_clk);
    cmp(obs, 39'h0);
    cmp(39'({clk48_en, decode_oe, in_suspend}), 39'h6);
    rst_b = 1;
    final_report();
  end
endmodule : test_chip_select_decoder
